// ===== rtl/arsr_regs.vh
// arsr_regs.vh: command-block addresses, bit positions, opcodes and timing counts
// assumes: included by the arsr design files only, by bare name
`ifndef ARSR_REGS_VH
`define ARSR_REGS_VH

// command-block register addresses
`define ARSR_ADDR_DATA 3'h0
`define ARSR_ADDR_ERRFEAT 3'h1
`define ARSR_ADDR_COUNT 3'h2
`define ARSR_ADDR_LBA_LO 3'h3
`define ARSR_ADDR_LBA_MID 3'h4
`define ARSR_ADDR_LBA_HI 3'h5
`define ARSR_ADDR_DEVICE 3'h6
`define ARSR_ADDR_STATCMD 3'h7

// opcodes
`define ARSR_OP_READ_EXT 8'h24
`define ARSR_OP_STREAM_DMA 8'h2a

// status bit positions
`define ARSR_ST_BSY 7
`define ARSR_ST_RDY 6
`define ARSR_ST_SE 5
`define ARSR_ST_DSC 4
`define ARSR_ST_DRQ 3
`define ARSR_ST_ERR 0

// error bit positions
`define ARSR_ER_CRC 7
`define ARSR_ER_UNC 6
`define ARSR_ER_IDNF 4
`define ARSR_ER_ABRT 2
`define ARSR_ER_CCTO 0

// feature current fields
`define ARSR_FT_RC 6
`define ARSR_FT_SID_HI 2
`define ARSR_FT_SID_LO 0

// reset values
`define ARSR_RST_BYTE 8'h00
`define ARSR_RST_DEVICE 8'h40

// timing: one microsecond tick from the 125 MHz core clock
`define ARSR_CLK_MHZ 125
`define ARSR_TICK_US 1
`define ARSR_TICK_CYCLES (`ARSR_TICK_US * `ARSR_CLK_MHZ)

`endif

// ===== rtl/arsr_fifo.v
// arsr_fifo.v: synchronous word fifo, valid/ready on both sides, flushable
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/1ns

module arsr_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire flush_in,
    input wire [WIDTH-1:0] in_data_in,
    input wire in_valid_in,
    output wire in_ready_out,
    output wire [WIDTH-1:0] out_data_out,
    output wire out_valid_out,
    input wire out_ready_in
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready_out = (count != DEPTH[AW:0]);
    assign out_valid_out = (count != {(AW+1){1'b0}});
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always @(posedge core_clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (flush_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // arsr_fifo

// ===== rtl/arsr_core.v
// arsr_core.v: device-side command block for the extended sector read and the streaming read
// assumes: host strobes are one-cycle and synchronous; media streams sector words in order
`timescale 1ns/1ns
`include "arsr_regs.vh"

module arsr_core #(
    parameter SECTOR_WORDS = 256,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4,
    parameter CCTL_UNIT_US = 1,
    parameter CCTL_MIN_US = 1
) (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire [2:0] host_addr_in,
    input wire [7:0] host_wdata_in,
    input wire host_wr_in,
    input wire host_rd_in,
    input wire host_hob_in,
    output reg [15:0] host_rdata_out,
    output wire [15:0] dma_data_out,
    output wire dma_valid_out,
    input wire dma_ready_in,
    output wire media_req_out,
    output reg [47:0] media_lba_out,
    input wire [15:0] media_data_in,
    input wire media_valid_in,
    input wire media_last_in,
    input wire [3:0] media_err_in,
    output wire media_ready_out,
    input wire [63:0] stream_cctl_in,
    output reg [7:0] errlog_out
);
    localparam S_IDLE = 2'h0;
    localparam S_RUN = 2'h1;
    localparam S_DRAIN = 2'h2;
    localparam [6:0] TICK_MAX = `ARSR_TICK_CYCLES - 1;

    reg [1:0] state;
    reg [7:0] feat_cur, feat_prev, cnt_cur, cnt_prev;
    reg [7:0] lo_cur, lo_prev, mid_cur, mid_prev, hi_cur, hi_prev;
    reg [7:0] device;
    reg [7:0] error;
    reg bsy, err, se, stream, rc, fail, err_seen, run_open;
    reg [16:0] sec_left;
    reg [16:0] run_cnt;
    reg [47:0] err_lba;
    reg [6:0] tick_cnt;
    reg [31:0] elapsed_us;
    reg [31:0] limit_us;
    reg lim_on;
    reg flush;

    wire [47:0] start_lba;
    wire [15:0] start_cnt;
    wire [2:0] sid;
    wire [7:0] dflt_cctl;
    wire [7:0] cctl_sel;
    wire [31:0] cctl_raw;
    wire fifo_in_ready, fifo_out_valid, fifo_pop, pio_pop;
    wire [15:0] fifo_out_data;
    wire word_take, sector_end, sec_bad, expired, tick;
    wire [7:0] err_bits;

    // the 48-bit start address and 16-bit count come from both slots
    assign start_lba = {hi_prev, mid_prev, lo_prev, hi_cur, mid_cur, lo_cur};
    assign start_cnt = {cnt_prev, cnt_cur};
    assign sid = feat_cur[`ARSR_FT_SID_HI:`ARSR_FT_SID_LO];
    assign dflt_cctl = stream_cctl_in[{sid, 3'h0} +: 8];
    assign cctl_sel = (feat_prev != 8'h00) ? feat_prev : dflt_cctl;
    assign cctl_raw = {24'h000000, cctl_sel} * CCTL_UNIT_US;

    assign tick = (tick_cnt == TICK_MAX);
    assign expired = stream && lim_on && (elapsed_us >= limit_us) && (state != S_IDLE);
    assign media_req_out = (state == S_RUN);
    assign media_ready_out = (state == S_RUN) && fifo_in_ready && !expired;
    assign word_take = media_ready_out && media_valid_in;
    assign sector_end = word_take && media_last_in;
    assign sec_bad = (media_err_in != 4'h0);
    assign err_bits = {media_err_in[3], media_err_in[2], 1'b0, media_err_in[1],
                       1'b0, media_err_in[0], 2'b00};

    // pio words leave through the data register, stream words through the dma port
    assign pio_pop = host_rd_in && (host_addr_in == `ARSR_ADDR_DATA) && !stream;
    assign dma_valid_out = stream && fifo_out_valid;
    assign fifo_pop = stream ? dma_ready_in : pio_pop;

    arsr_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .flush_in(flush),
        .in_data_in(media_data_in),
        .in_valid_in(word_take),
        .in_ready_out(fifo_in_ready),
        .out_data_out(fifo_out_data),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop)
    );
    assign dma_data_out = fifo_out_data;

    // microsecond base for the completion limit, counted from the command write
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tick_cnt <= 7'h00;
            elapsed_us <= 32'h00000000;
        end else if (state == S_IDLE) begin
            tick_cnt <= 7'h00;
            elapsed_us <= 32'h00000000;
        end else begin
            tick_cnt <= tick ? 7'h00 : tick_cnt + 7'h01;
            if (tick && (elapsed_us != 32'hffffffff)) begin
                elapsed_us <= elapsed_us + 32'h00000001;
            end
        end
    end

    // host register reads; hob picks the previous byte of each pair
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            host_rdata_out <= 16'h0000;
        end else if (host_rd_in) begin
            case (host_addr_in)
                `ARSR_ADDR_DATA: host_rdata_out <= (!stream && fifo_out_valid) ?
                                                   fifo_out_data : 16'h0000;
                `ARSR_ADDR_ERRFEAT: host_rdata_out <= {8'h00, error};
                `ARSR_ADDR_COUNT: host_rdata_out <= {8'h00, host_hob_in ? cnt_prev : cnt_cur};
                `ARSR_ADDR_LBA_LO: host_rdata_out <= {8'h00, host_hob_in ? lo_prev : lo_cur};
                `ARSR_ADDR_LBA_MID: host_rdata_out <= {8'h00, host_hob_in ? mid_prev : mid_cur};
                `ARSR_ADDR_LBA_HI: host_rdata_out <= {8'h00, host_hob_in ? hi_prev : hi_cur};
                `ARSR_ADDR_DEVICE: host_rdata_out <= {8'h00, device};
                `ARSR_ADDR_STATCMD: host_rdata_out <= {8'h00, bsy, 1'b1, stream & se, ~stream,
                                                       bsy & ~stream & fifo_out_valid,
                                                       2'b00, err};
                default: host_rdata_out <= 16'h0000;
            endcase
        end
    end

    // command block, sequencing and ending status
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= S_IDLE;
            feat_cur <= `ARSR_RST_BYTE;
            feat_prev <= `ARSR_RST_BYTE;
            cnt_cur <= `ARSR_RST_BYTE;
            cnt_prev <= `ARSR_RST_BYTE;
            lo_cur <= `ARSR_RST_BYTE;
            lo_prev <= `ARSR_RST_BYTE;
            mid_cur <= `ARSR_RST_BYTE;
            mid_prev <= `ARSR_RST_BYTE;
            hi_cur <= `ARSR_RST_BYTE;
            hi_prev <= `ARSR_RST_BYTE;
            device <= `ARSR_RST_DEVICE;
            error <= `ARSR_RST_BYTE;
            errlog_out <= `ARSR_RST_BYTE;
            bsy <= 1'b0;
            err <= 1'b0;
            se <= 1'b0;
            stream <= 1'b0;
            rc <= 1'b0;
            fail <= 1'b0;
            err_seen <= 1'b0;
            run_open <= 1'b0;
            sec_left <= 17'h00000;
            run_cnt <= 17'h00000;
            err_lba <= 48'h000000000000;
            media_lba_out <= 48'h000000000000;
            limit_us <= 32'h00000000;
            lim_on <= 1'b0;
            flush <= 1'b0;
        end else begin
            flush <= 1'b0;
            case (state)
                S_IDLE: begin
                    // writes while busy are ignored; each feature, count or lba write ages current to previous
                    if (host_wr_in) begin
                        case (host_addr_in)
                            `ARSR_ADDR_ERRFEAT: begin
                                feat_prev <= feat_cur;
                                feat_cur <= host_wdata_in;
                            end
                            `ARSR_ADDR_COUNT: begin
                                cnt_prev <= cnt_cur;
                                cnt_cur <= host_wdata_in;
                            end
                            `ARSR_ADDR_LBA_LO: begin
                                lo_prev <= lo_cur;
                                lo_cur <= host_wdata_in;
                            end
                            `ARSR_ADDR_LBA_MID: begin
                                mid_prev <= mid_cur;
                                mid_cur <= host_wdata_in;
                            end
                            `ARSR_ADDR_LBA_HI: begin
                                hi_prev <= hi_cur;
                                hi_cur <= host_wdata_in;
                            end
                            `ARSR_ADDR_DEVICE: device <= host_wdata_in;
                            `ARSR_ADDR_STATCMD: begin
                                err <= 1'b0;
                                se <= 1'b0;
                                error <= 8'h00;
                                fail <= 1'b0;
                                err_seen <= 1'b0;
                                run_open <= 1'b0;
                                run_cnt <= 17'h00000;
                                media_lba_out <= start_lba;
                                // a zero count asks for the full 65536 sectors
                                sec_left <= (start_cnt == 16'h0000) ? 17'h10000 :
                                            {1'b0, start_cnt};
                                flush <= 1'b1;
                                if (host_wdata_in == `ARSR_OP_READ_EXT) begin
                                    bsy <= 1'b1;
                                    stream <= 1'b0;
                                    rc <= 1'b0;
                                    lim_on <= 1'b0;
                                    state <= S_RUN;
                                end else if (host_wdata_in == `ARSR_OP_STREAM_DMA) begin
                                    bsy <= 1'b1;
                                    stream <= 1'b1;
                                    rc <= feat_cur[`ARSR_FT_RC];
                                    errlog_out <= 8'h00;
                                    lim_on <= (cctl_sel != 8'h00);
                                    limit_us <= (cctl_raw < CCTL_MIN_US) ? CCTL_MIN_US :
                                                cctl_raw;
                                    state <= S_RUN;
                                end else begin
                                    // unknown opcodes end at once with an abort
                                    err <= 1'b1;
                                    error <= 8'h04;
                                end
                            end
                            default: device <= device;
                        endcase
                    end
                end
                S_RUN, S_DRAIN: begin
                    if (sector_end) begin
                        sec_left <= sec_left - 17'h00001;
                        media_lba_out <= media_lba_out + 48'h000000000001;
                        if (sec_bad && rc) begin
                            // continuous mode keeps going and only logs the fault
                            errlog_out <= errlog_out | err_bits;
                            se <= 1'b1;
                            if (!err_seen) begin
                                err_seen <= 1'b1;
                                err_lba <= media_lba_out;
                                run_cnt <= 17'h00001;
                                run_open <= 1'b1;
                            end else if (run_open) begin
                                run_cnt <= run_cnt + 17'h00001;
                            end
                        end else if (sec_bad) begin
                            // stop here; the failing sector's words still drain
                            fail <= 1'b1;
                            err_lba <= media_lba_out;
                            error <= err_bits;
                            state <= S_DRAIN;
                        end else begin
                            run_open <= 1'b0;
                        end
                        if (sec_left == 17'h00001) begin
                            state <= S_DRAIN;
                        end
                    end
                    if (expired) begin
                        // time is up: drop what is queued and end now
                        flush <= 1'b1;
                        bsy <= 1'b0;
                        state <= S_IDLE;
                        if (rc) begin
                            errlog_out <= errlog_out | 8'h01;
                            se <= 1'b1;
                            err <= 1'b0;
                        end else begin
                            err <= 1'b1;
                            error <= error | 8'h01;
                        end
                    end else if ((state == S_DRAIN) && !fifo_out_valid && !sector_end) begin
                        bsy <= 1'b0;
                        err <= fail && !rc;
                        state <= S_IDLE;
                        if (fail || err_seen) begin
                            {hi_prev, mid_prev, lo_prev, hi_cur, mid_cur, lo_cur} <= err_lba;
                            cnt_prev <= fail ? sec_left[15:8] : run_cnt[15:8];
                            cnt_cur <= fail ? sec_left[7:0] : run_cnt[7:0];
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // arsr_core

// ===== test/arsr_core_assertions.sv
// arsr_core_assertions.sv: port-level checker for arsr_core
// assumes: bound to arsr_core, one clock, async active-low reset
`timescale 1ns/1ns
module arsr_core_assertions (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire [2:0] host_addr_in,
    input wire [7:0] host_wdata_in,
    input wire host_wr_in,
    input wire host_rd_in,
    input wire [15:0] host_rdata_out,
    input wire [15:0] dma_data_out,
    input wire dma_valid_out,
    input wire dma_ready_in,
    input wire media_req_out,
    input wire [47:0] media_lba_out,
    input wire media_valid_in,
    input wire media_last_in,
    input wire media_ready_out,
    input wire [7:0] errlog_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    wire last_take = media_valid_in && media_ready_out && media_last_in;
    wire cmd_wr = host_wr_in && host_addr_in == 3'h7;

    a_rdata_holds: assert property (!host_rd_in |=> $stable(host_rdata_out))
        else $error("read data changed without a read");
    a_start_cmd: assert property ($rose(media_req_out) |-> $past(cmd_wr))
        else $error("media fetch began without a command write");
    a_idle_no_accept: assert property (!media_req_out |-> !media_ready_out)
        else $error("media word accepted while not fetching");
    a_lba_hold: assert property (media_req_out && !last_take |=> $stable(media_lba_out))
        else $error("sector address moved inside a sector");
    a_lba_step: assert property (last_take ##1 media_req_out
        |-> media_lba_out == $past(media_lba_out) + 48'h1)
        else $error("sector address did not step by one");
    a_dma_hold: assert property (dma_valid_out && !dma_ready_in && media_req_out
        |=> !media_req_out || errlog_out[0] || (dma_valid_out && $stable(dma_data_out)))
        else $error("stream word dropped or changed while stalled");
    a_errlog_clear: assert property (cmd_wr && host_wdata_in == 8'h2a && !media_req_out
        && !dma_valid_out |=> errlog_out == 8'h00)
        else $error("error log not cleared at stream start");
    a_status_shape: assert property (host_rd_in && host_addr_in == 3'h7
        |=> host_rdata_out[6] && host_rdata_out[2:1] == 2'b00)
        else $error("status byte has wrong fixed bits");

    c_timeout: cover property ($rose(errlog_out[0]));
    c_stall: cover property (dma_valid_out && !dma_ready_in);
    c_fetch: cover property ($rose(media_req_out));
endmodule // arsr_core_assertions

// ===== test/arsr_media_model.sv
// arsr_media_model.sv: media side, streams sector words, injects one bad sector
// assumes: word = {lba low byte, word index}; sector of WORDS words
`timescale 1ns/1ns
module arsr_media_model #(parameter WORDS = 4) (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire req_in,
    input wire [47:0] lba_in,
    input wire ready_in,
    input wire slow_in,
    input wire [47:0] bad_lba_in,
    input wire [3:0] bad_code_in,
    output logic [15:0] data_out,
    output logic valid_out,
    output logic last_out,
    output logic [3:0] err_out
);
    logic [7:0] idx;
    // idle data is inverted so a stale word never looks valid
    assign data_out = valid_out ? {lba_in[7:0], idx} : ~{lba_in[7:0], idx};
    assign last_out = valid_out && idx == WORDS - 1;
    assign err_out = (last_out && lba_in == bad_lba_in) ? bad_code_in : 4'h0;
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            idx <= 8'h00;
            valid_out <= 1'b0;
        end else if (valid_out && ready_in) begin
            idx <= last_out ? 8'h00 : idx + 8'h01;
            valid_out <= req_in && !slow_in;
        end else begin
            valid_out <= req_in;
            if (!req_in)
                idx <= 8'h00;
        end
    end
endmodule // arsr_media_model

// ===== test/tb_arsr_core.sv
// tb_arsr_core.sv: self-checking bench for the extended and streaming reads
// assumes: arsr_core, media model and checker compiled first
`timescale 1ns/1ns
module tb_arsr_core;
    logic core_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic hob = 1'b0;
    logic dma_ready = 1'b0;
    logic slow = 1'b0;
    logic [47:0] bad_lba = 48'hffff_ffff_ffff;
    logic [3:0] bad_code = 4'h0;
    logic [63:0] cctl = 64'h0000_0000_0200_0000;
    wire [15:0] rdata, dma_data, m_data;
    wire [47:0] m_lba;
    wire [7:0] errlog;
    wire [3:0] m_err;
    wire dma_valid, m_req, m_valid, m_last, m_ready;
    int bad_count = 0;
    int tests_run = 0;
    logic [15:0] q;

    arsr_core arsr_core_i (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .host_addr_in(addr), .host_wdata_in(wdata), .host_wr_in(wr), .host_rd_in(rd),
        .host_hob_in(hob), .host_rdata_out(rdata), .dma_data_out(dma_data),
        .dma_valid_out(dma_valid), .dma_ready_in(dma_ready), .media_req_out(m_req),
        .media_lba_out(m_lba), .media_data_in(m_data), .media_valid_in(m_valid),
        .media_last_in(m_last), .media_err_in(m_err), .media_ready_out(m_ready),
        .stream_cctl_in(cctl), .errlog_out(errlog));
    arsr_media_model arsr_media_model_i (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .req_in(m_req), .lba_in(m_lba), .ready_in(m_ready), .slow_in(slow),
        .bad_lba_in(bad_lba), .bad_code_in(bad_code), .data_out(m_data),
        .valid_out(m_valid), .last_out(m_last), .err_out(m_err));

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, input logic h, output logic [15:0] v);
        @(posedge core_clk_in);
        addr <= a;
        hob <= h;
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        @(negedge core_clk_in);
        v = rdata;
    endtask

    task automatic issue(input logic [15:0] c, input logic [47:0] a, input logic [7:0] fc,
                         input logic [7:0] fp, input logic [7:0] op);
        wr_reg(3'h1, fp);
        wr_reg(3'h1, fc);
        wr_reg(3'h2, c[15:8]);
        wr_reg(3'h2, c[7:0]);
        wr_reg(3'h3, a[31:24]);
        wr_reg(3'h3, a[7:0]);
        wr_reg(3'h4, a[39:32]);
        wr_reg(3'h4, a[15:8]);
        wr_reg(3'h5, a[47:40]);
        wr_reg(3'h5, a[23:16]);
        wr_reg(3'h7, op);
    endtask

    task automatic idle(input logic [15:0] st);
        int n;
        n = 0;
        rd_reg(3'h7, 1'b0, q);
        while (q[7] !== 1'b0 && n < 900) begin
            rd_reg(3'h7, 1'b0, q);
            n++;
        end
        chk(q, st);
    endtask

    task automatic chk_lba(input logic [47:0] a, input logic [15:0] c);
        int i;
        for (i = 0; i < 3; i++) begin
            rd_reg(3'h3 + 3'(i), 1'b0, q);
            chk(q, {8'h00, 8'(a >> (8 * i))});
            rd_reg(3'h3 + 3'(i), 1'b1, q);
            chk(q, {8'h00, 8'(a >> (8 * i + 24))});
        end
        rd_reg(3'h2, 1'b0, q);
        chk(q, {8'h00, c[7:0]});
        rd_reg(3'h2, 1'b1, q);
        chk(q, {8'h00, c[15:8]});
    endtask

    task automatic pio_words(input int n, input logic [7:0] lb);
        int k;
        int w;
        for (k = 0; k < n; k++) begin
            w = 0;
            rd_reg(3'h7, 1'b0, q);
            while (q[3] !== 1'b1 && w < 50) begin
                rd_reg(3'h7, 1'b0, q);
                w++;
            end
            rd_reg(3'h0, 1'b0, q);
            chk(q, {lb + 8'(k / 4), 8'(k % 4)});
        end
    endtask

    // ready toggles every two cycles so the stream sees stalls
    task automatic dma_get(input int n, input logic [7:0] lb);
        int got;
        int t;
        got = 0;
        for (t = 0; t < 5000 && got < n; t++) begin
            @(posedge core_clk_in);
            dma_ready <= t[1];
            @(negedge core_clk_in);
            if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
                chk(dma_data, {lb + 8'(got / 4), 8'(got % 4)});
                got++;
            end
        end
        chk(16'(got), 16'(n));
    endtask

    task automatic s_reset;
        rd_reg(3'h7, 1'b0, q);
        chk(q, 16'h0050);
    endtask

    task automatic s_pio;
        issue(16'h0002, 48'h10, 8'h00, 8'h00, 8'h24);
        pio_words(8, 8'h10);
        idle(16'h0050);
    endtask

    task automatic s_pio_err;
        @(posedge core_clk_in);
        slow <= 1'b1;
        bad_lba <= 48'h6655_4433_2221;
        bad_code <= 4'b0100;
        issue(16'h0003, 48'h6655_4433_2220, 8'h00, 8'h00, 8'h24);
        pio_words(8, 8'h20);
        idle(16'h0051);
        rd_reg(3'h1, 1'b0, q);
        chk(q, 16'h0040);
        // the failing sector's words were delivered, so only the one after it is left
        chk_lba(48'h6655_4433_2221, 16'h0001);
    endtask

    task automatic s_rc0;
        @(posedge core_clk_in);
        slow <= 1'b0;
        bad_lba <= 48'h30;
        bad_code <= 4'b1000;
        issue(16'h0002, 48'h30, 8'h00, 8'h05, 8'h2a);
        dma_get(4, 8'h30);
        idle(16'h0041);
        rd_reg(3'h1, 1'b0, q);
        chk(q, 16'h0080);
    endtask

    task automatic s_rc1;
        @(posedge core_clk_in);
        slow <= 1'b1;
        bad_lba <= 48'h42;
        bad_code <= 4'b0011;
        issue(16'h0101, 48'h40, 8'h40, 8'h00, 8'h2a);
        dma_get(1028, 8'h40);
        idle(16'h0060);
        chk({8'h00, errlog}, 16'h0014);
        chk_lba(48'h42, 16'h0001);
    endtask

    task automatic s_timeout;
        @(posedge core_clk_in);
        slow <= 1'b0;
        bad_lba <= 48'hffff_ffff_ffff;
        issue(16'h0000, 48'h80, 8'h43, 8'h00, 8'h2a);
        dma_get(40, 8'h80);
        idle(16'h0060);
        chk({8'h00, errlog}, 16'h0001);
    endtask

    // limit of one microsecond with continuous mode off: err and error bit0, log untouched
    task automatic s_rc0_late;
        issue(16'h0000, 48'ha0, 8'h00, 8'h01, 8'h2a);
        dma_get(20, 8'ha0);
        idle(16'h0041);
        rd_reg(3'h1, 1'b0, q);
        chk(q, 16'h0001);
        chk({8'h00, errlog}, 16'h0000);
    endtask

    initial begin
        forever #4 core_clk_in = ~core_clk_in;
    end

    initial begin
        repeat (2) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        s_reset();
        s_pio();
        s_pio_err();
        s_rc0();
        s_rc1();
        s_timeout();
        s_rc0_late();
        complete_run();
    end

    // the whole sequence needs under 10000 cycles
    initial begin
        #200000;
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule // tb_arsr_core

bind arsr_core arsr_core_assertions arsr_core_assertions_i (.*);
